// ===== logic/rx_fifo_reject_filter.sv
// Contract
// - sync/single-slot mode reserves buffer 0 (and 1)
// - no validity check on partition indices
// - at most 128 buffers exist
// - data section at most 254 bytes
// - fifo buffers locked outside config states
// - reject filter writable only in config
// - lane filter: 11 none, 10 A, 01 B, 00 both
// - both lanes stored, even identical frames
// - 11-bit frame id names id to reject
// - zero mask and zero id reject nothing
// - outside cycle set every frame is rejected
// - reject static slots bit drops static frames
// - reject null frames bit drops null frames
// - mask bit one excludes id bit
// - id mask writable only in config
// - threshold writable only in config
// - flag set when fill reaches threshold
// - threshold above 128 never sets flag
// - flag rising edge sets status irq flag
// - first queue index through last forms fifo
// - flag clears when fill drops below threshold
// - fill level counts unread buffers, max 128
`timescale 1ns/1ps
module rx_fifo_reject_filter
  import rx_fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic config_state,
  input wire rx_frame_t rx_frame,
  input wire logic fifo_pop,
  input wire logic hdr_wr_req,
  input wire logic [6:0] hdr_wr_index,
  input wire logic [7:0] hdr_wr_words,
  output logic hdr_wr_allow,
  output logic fifo_store,
  output logic fifo_overrun,
  output logic [7:0] fifo_fill_level,
  output logic fifo_threshold_flag,
  output logic threshold_irq
);

  state_t st_reg;
  state_t st_next;

  ////////////////////////////////////////////////////////////////////////////////
  // cycle set: highest set bit picks the repetition, bits below it the base
  function automatic logic cycle_in_set(input logic [6:0] cset, input logic [5:0] cyc);
    logic [6:0] rep_mask;
    integer i;
    rep_mask = 7'h00;
    for (i = 0; i < 7; i++) begin
      if (cset[i]) begin
        rep_mask = 7'(7'h7F >> (7 - i));
      end
    end
    return ((({1'b0, cyc} ^ cset) & rep_mask) == 7'h00);
  endfunction : cycle_in_set

  ////////////////////////////////////////////////////////////////////////////////
  // decoded apb strobes; no wait states, so pready is tied high
  logic setup_phase;
  logic wr_access;
  logic mapped;
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign mapped = (paddr == ADDR_PARTITION) || (paddr == ADDR_REJECT) ||
                  (paddr == ADDR_MASK) || (paddr == ADDR_THRESH) ||
                  (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // fifo extent; indices are trusted as written
  logic fifo_exists;
  logic [7:0] fifo_size;
  always_comb begin
    // top index bit set means the group is absent
    fifo_exists = !st_reg.first_queue_buffer[7] && !st_reg.last_configured_buffer[7] &&
                  (st_reg.last_configured_buffer >= st_reg.first_queue_buffer);
    // size never exceeds the 128 header sections
    fifo_size = fifo_exists ?
                8'(st_reg.last_configured_buffer - st_reg.first_queue_buffer + 8'h01) :
                8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // rejection criteria on the incoming frame
  logic id_hit;
  logic lane_ok;
  logic cyc_ok;
  logic accept;
  always_comb begin
    // masked bits drop out, widening the rejected set
    id_hit = (((rx_frame.frame_id ^ st_reg.frame_id_filter) & ~st_reg.mask) ==
              11'h000);
    if ((st_reg.mask == 11'h000) && (st_reg.frame_id_filter == 11'h000)) begin
      id_hit = 1'b0;
    end
    case (st_reg.lane)
      LANE_NONE: lane_ok = 1'b0;
      LANE_A_ONLY: lane_ok = !rx_frame.lane_b;
      LANE_B_ONLY: lane_ok = rx_frame.lane_b;
      default: lane_ok = 1'b1;
    endcase
    cyc_ok = cycle_in_set(st_reg.cycle_set_filter, rx_frame.cycle);
    // no dedupe across lanes: each lane's copy stands alone
    accept = rx_frame.valid && cyc_ok && lane_ok && !id_hit &&
             !(st_reg.reject_static_slots && rx_frame.in_static) &&
             !(st_reg.reject_null_frames && rx_frame.is_null) &&
             fifo_exists;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // header write gate for the message buffer store
  logic in_fifo;
  logic key_slot;
  always_comb begin
    in_fifo = fifo_exists && ({1'b0, hdr_wr_index} >= st_reg.first_queue_buffer) &&
              ({1'b0, hdr_wr_index} <= st_reg.last_configured_buffer);
    // reserved buffers only when the node sends sync or single-slot frames
    key_slot = (st_reg.sync_en || st_reg.ssm) &&
               ((hdr_wr_index == 7'h00) || (st_reg.spl && (hdr_wr_index == 7'h01)));
    hdr_wr_allow = hdr_wr_req && (hdr_wr_words <= MAX_SECTION_WORDS) &&
                   (config_state || (!in_fifo && !key_slot));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state: registers, fill level, flag, status and read data
  always_comb begin
    st_next = st_reg;
    st_next.store = 1'b0;
    st_next.overrun = 1'b0;
    // configuration writes; out of config they are dropped silently
    if (wr_access && config_state) begin
      case (paddr)
        ADDR_PARTITION: begin
          // partition is taken as written, even if inconsistent
          st_next.first_dynamic_buffer = pwdata[PART_FIRST_DYN_LSB +: 8];
          st_next.first_queue_buffer = pwdata[PART_FIRST_QUEUE_LSB +: 8];
          st_next.last_configured_buffer = pwdata[PART_LAST_CFG_LSB +: 8];
          st_next.spl = pwdata[PART_SPL_BIT];
          st_next.sync_en = pwdata[PART_SYNC_BIT];
          st_next.ssm = pwdata[PART_SSM_BIT];
        end
        ADDR_REJECT: begin
          st_next.lane = pwdata[REJ_LANE_LSB +: 2];
          st_next.frame_id_filter = pwdata[REJ_FRAME_ID_LSB +: 11];
          st_next.cycle_set_filter = pwdata[REJ_CYCLE_SET_LSB +: 7];
          st_next.reject_static_slots = pwdata[REJ_STATIC_BIT];
          st_next.reject_null_frames = pwdata[REJ_NULL_BIT];
        end
        ADDR_MASK: st_next.mask = pwdata[MASK_LSB +: 11];
        ADDR_THRESH: st_next.thresh = pwdata[THRESH_LSB +: 8];
        default: ;
      endcase
    end
    // enable is free at any time, unlike the filter settings
    if (wr_access && (paddr == ADDR_IRQ)) begin
      st_next.irq_en = pwdata[IRQ_EN_BIT];
      if (pwdata[IRQ_FLAG_BIT]) begin
        st_next.irq_flag = 1'b0;
      end
    end
    // fill level: store and pop together leave it unchanged
    if (accept) begin
      if (st_reg.fill >= fifo_size) begin
        // oldest entry gets overwritten, count stays put
        st_next.overrun = 1'b1;
        st_next.store = 1'b1;
        if (fifo_pop && (st_reg.fill != 8'h00)) begin
          st_next.fill = st_reg.fill;
        end
      end else begin
        st_next.store = 1'b1;
        if (!(fifo_pop && (st_reg.fill != 8'h00))) begin
          st_next.fill = 8'(st_reg.fill + 8'h01);
        end
      end
    end else if (fifo_pop && (st_reg.fill != 8'h00)) begin
      st_next.fill = 8'(st_reg.fill - 8'h01);
    end
    // threshold compare; values above 128 can never be met
    st_next.flag = (st_reg.thresh <= MAX_BUFFERS) &&
                   (st_reg.fill >= st_reg.thresh);
    // rising edge sets the sticky flag; set beats a same-cycle clear
    if (st_next.flag && !st_reg.flag) begin
      st_next.irq_flag = 1'b1;
    end
    // read data is latched in the setup phase so access needs no wait
    if (setup_phase) begin
      st_next.rdata = 32'h0000_0000;
      case (paddr)
        ADDR_PARTITION: begin
          st_next.rdata[PART_FIRST_DYN_LSB +: 8] = st_reg.first_dynamic_buffer;
          st_next.rdata[PART_FIRST_QUEUE_LSB +: 8] = st_reg.first_queue_buffer;
          st_next.rdata[PART_LAST_CFG_LSB +: 8] = st_reg.last_configured_buffer;
          st_next.rdata[PART_SPL_BIT] = st_reg.spl;
          st_next.rdata[PART_SYNC_BIT] = st_reg.sync_en;
          st_next.rdata[PART_SSM_BIT] = st_reg.ssm;
        end
        ADDR_REJECT: begin
          st_next.rdata[REJ_LANE_LSB +: 2] = st_reg.lane;
          st_next.rdata[REJ_FRAME_ID_LSB +: 11] = st_reg.frame_id_filter;
          st_next.rdata[REJ_CYCLE_SET_LSB +: 7] = st_reg.cycle_set_filter;
          st_next.rdata[REJ_STATIC_BIT] = st_reg.reject_static_slots;
          st_next.rdata[REJ_NULL_BIT] = st_reg.reject_null_frames;
        end
        ADDR_MASK: st_next.rdata[MASK_LSB +: 11] = st_reg.mask;
        ADDR_THRESH: st_next.rdata[THRESH_LSB +: 8] = st_reg.thresh;
        ADDR_STATUS: begin
          st_next.rdata[STAT_NE_BIT] = (st_reg.fill != 8'h00);
          st_next.rdata[STAT_FLAG_BIT] = st_reg.flag;
          st_next.rdata[STAT_FILL_LSB +: 8] = st_reg.fill;
        end
        ADDR_IRQ: begin
          st_next.rdata[IRQ_FLAG_BIT] = st_reg.irq_flag;
          st_next.rdata[IRQ_EN_BIT] = st_reg.irq_en;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      // index 128 in all three: no buffers and no fifo until software sets them
      st_reg.first_dynamic_buffer <= PART_IDX_RESET;
      st_reg.first_queue_buffer <= PART_IDX_RESET;
      st_reg.last_configured_buffer <= PART_IDX_RESET;
      st_reg.thresh <= THRESH_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign prdata = st_reg.rdata;
  assign fifo_store = st_reg.store;
  assign fifo_overrun = st_reg.overrun;
  assign fifo_fill_level = st_reg.fill;
  assign fifo_threshold_flag = st_reg.flag;
  assign threshold_irq = st_reg.irq_flag && st_reg.irq_en;

endmodule : rx_fifo_reject_filter

// ===== logic/rx_fifo_pkg.sv
package rx_fifo_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte addresses (apb, one aligned word each)
  localparam logic [11:0] ADDR_PARTITION = 12'h300;
  localparam logic [11:0] ADDR_REJECT = 12'h304;
  localparam logic [11:0] ADDR_MASK = 12'h308;
  localparam logic [11:0] ADDR_THRESH = 12'h30C;
  localparam logic [11:0] ADDR_STATUS = 12'h310;
  localparam logic [11:0] ADDR_IRQ = 12'h314;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PART_FIRST_DYN_LSB = 0;
  localparam int PART_FIRST_QUEUE_LSB = 8;
  localparam int PART_LAST_CFG_LSB = 16;
  localparam int PART_SPL_BIT = 24;
  localparam int PART_SYNC_BIT = 25;
  localparam int PART_SSM_BIT = 26;
  localparam int REJ_LANE_LSB = 0;
  localparam int REJ_FRAME_ID_LSB = 2;
  localparam int REJ_CYCLE_SET_LSB = 16;
  localparam int REJ_STATIC_BIT = 23;
  localparam int REJ_NULL_BIT = 24;
  localparam int MASK_LSB = 2;
  localparam int THRESH_LSB = 0;
  localparam int STAT_NE_BIT = 0;
  localparam int STAT_FLAG_BIT = 1;
  localparam int STAT_FILL_LSB = 8;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic [7:0] PART_IDX_RESET = 8'h80;
  localparam logic [7:0] THRESH_RESET = 8'h80;
  localparam logic [7:0] MAX_BUFFERS = 8'h80;
  localparam logic [7:0] MAX_SECTION_WORDS = 8'h7F;
  localparam logic [1:0] LANE_NONE = 2'b11;
  localparam logic [1:0] LANE_A_ONLY = 2'b10;
  localparam logic [1:0] LANE_B_ONLY = 2'b01;

  // frame delivered by the protocol engine
  typedef struct packed {
    logic valid;
    logic lane_b;
    logic [10:0] frame_id;
    logic [5:0] cycle;
    logic in_static;
    logic is_null;
  } rx_frame_t;

  // whole state of the filter block
  typedef struct packed {
    logic [7:0] first_dynamic_buffer;
    logic [7:0] first_queue_buffer;
    logic [7:0] last_configured_buffer;
    logic spl;
    logic sync_en;
    logic ssm;
    logic [1:0] lane;
    logic [10:0] frame_id_filter;
    logic [6:0] cycle_set_filter;
    logic reject_static_slots;
    logic reject_null_frames;
    logic [10:0] mask;
    logic [7:0] thresh;
    logic [7:0] fill;
    logic flag;
    logic irq_flag;
    logic irq_en;
    logic store;
    logic overrun;
    logic [31:0] rdata;
  } state_t;

endpackage : rx_fifo_pkg

// ===== test/rx_fifo_reject_filter_monitor.sv
`timescale 1ns/1ps
module rx_fifo_reject_filter_monitor
  import rx_fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic config_state,
  input wire rx_frame_t rx_frame,
  input wire logic fifo_pop,
  input wire logic hdr_wr_req,
  input wire logic [7:0] hdr_wr_words,
  input wire logic hdr_wr_allow,
  input wire logic fifo_store,
  input wire logic fifo_overrun,
  input wire logic [7:0] fifo_fill_level,
  input wire logic fifo_threshold_flag,
  input wire logic threshold_irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // fill bookkeeping, stable unless a store, pop, bus access or state change
  store_after_frame_a: assert property (fifo_store |-> $past(rx_frame.valid))
    else $error("store without a frame");
  overrun_store_a: assert property (fifo_overrun |-> fifo_store)
    else $error("overrun without store");
  fill_up_a: assert property (fifo_store && !fifo_overrun && !$past(fifo_pop)
    |-> fifo_fill_level == $past(fifo_fill_level) + 8'h01) else $error("fill not raised");
  fill_hold_a: assert property (!fifo_store && !$past(fifo_pop) && !$past(psel)
    && $stable(config_state) |-> $stable(fifo_fill_level)) else $error("fill moved");
  fill_max_a: assert property (fifo_fill_level <= 8'h80)
    else $error("fill above limit");
  ////////////////////////////////////////////////////////////////////////////////
  // sticky status only falls by a bus write, rises with the flag or enable
  irq_clear_a: assert property ($fell(threshold_irq) |-> $past(psel && penable && pwrite))
    else $error("irq dropped by itself");
  irq_raise_a: assert property ($rose(threshold_irq) |-> $rose(fifo_threshold_flag)
    || $past(psel && penable && pwrite)) else $error("irq rose without cause");
  ////////////////////////////////////////////////////////////////////////////////
  // buffer reconfiguration gate
  hdr_len_a: assert property (hdr_wr_allow |-> hdr_wr_req && hdr_wr_words <= 8'h7F)
    else $error("oversized section allowed");
  hdr_cfg_a: assert property (config_state && hdr_wr_req && hdr_wr_words <= 8'h7F
    |-> hdr_wr_allow) else $error("config write refused");
endmodule : rx_fifo_reject_filter_monitor

bind rx_fifo_reject_filter rx_fifo_reject_filter_monitor u_rx_fifo_reject_filter_monitor (.*);

// ===== test/rx_fifo_host_model.sv
`timescale 1ns/1ps
module rx_fifo_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drain,
  input wire logic slow,
  input wire logic [7:0] fifo_fill_level,
  output logic fifo_pop
);
  logic [1:0] gap;
  ////////////////////////////////////////////////////////////////////////////////
  // reads only while not empty; at most every other cycle, every fourth when slow, so fill is fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 2'h0;
      fifo_pop <= 1'b0;
    end else begin
      gap <= gap + 2'h1;
      fifo_pop <= drain && fifo_fill_level != 8'h00 && !fifo_pop && (!slow || gap == 2'h0);
    end
  end
endmodule : rx_fifo_host_model

// ===== test/test_rx_fifo_reject_filter.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_rx_fifo_reject_filter;
  import rx_fifo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, config_state, fifo_pop, s;
  logic hdr_wr_req, hdr_wr_allow, fifo_store, fifo_overrun, fifo_threshold_flag;
  logic threshold_irq, drain, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0] hdr_wr_index;
  logic [7:0] hdr_wr_words, fifo_fill_level;
  rx_frame_t rx_frame;
  int n_errors, total_checks;
  rx_fifo_reject_filter u_rx_fifo_reject_filter (.*);
  rx_fifo_host_model u_rx_fifo_host_model (.*);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // a bounded wait that runs out at 200 cycles is a mismatch and ends the run
  task tmo(input int n);
    if (n >= 200) begin
      n_errors++;
      stop_test();
    end
  endtask : tmo
  // one apb transfer, released only after pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    r = prdata;
    s = pslverr;
    tmo(n);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic rx_frame_t fr(logic lb, logic [10:0] id, logic [5:0] cy, logic st, logic nl);
    return {1'b1, lb, id, cy, st, nl};
  endfunction : fr
  function automatic logic [31:0] rj(logic [1:0] ln, logic [10:0] id, logic [6:0] cy, logic rs,
                                     logic rn);
    return {7'h00, rn, rs, cy, 3'h0, id, ln};
  endfunction : rj
  // filter setup then one frame; store pulse is looked at in its own cycle
  task frame(input logic [31:0] rej, input logic [10:0] msk, input rx_frame_t f, input logic e);
    apb(1'b1, ADDR_REJECT, rej);
    apb(1'b1, ADDR_MASK, {19'h00000, msk, 2'h0});
    rx_frame <= f;
    @(posedge pclk);
    rx_frame.valid <= 1'b0;
    @(negedge pclk);
    `CHK(fifo_store, e)
    @(posedge pclk);
  endtask : frame
  task drain_all(input logic sl);
    int n;
    n = 0;
    slow <= sl;
    drain <= 1'b1;
    while (fifo_fill_level !== 8'h00 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    tmo(n);
    drain <= 1'b0;
    @(posedge pclk);
  endtask : drain_all
  task hdr(input logic [6:0] i, input logic [7:0] w, input logic e);
    hdr_wr_req <= 1'b1;
    hdr_wr_index <= i;
    hdr_wr_words <= w;
    @(negedge pclk);
    `CHK(hdr_wr_allow, e)
    @(posedge pclk);
  endtask : hdr
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(1'b0, ADDR_THRESH, 32'h0);
    `CHK(r, 32'h00000080)
    apb(1'b1, ADDR_THRESH, 32'h00000005);
    apb(1'b0, ADDR_THRESH, 32'h0);
    `CHK(r, 32'h00000080)
    apb(1'b1, ADDR_MASK, 32'h00001FFC);
    apb(1'b0, ADDR_MASK, 32'h0);
    `CHK(r, 32'h00000000)
    frame(32'h00000003, 11'h7FF, fr(1'b0, 11'h009, 6'h00, 1'b0, 1'b0), 1'b0);
    apb(1'b0, ADDR_REJECT, 32'h0);
    `CHK(r, 32'h00000000)
    apb(1'b0, 12'h3F0, 32'h0);
    `CHK(s, 1'b1)
    $display("t_regs done");
  endtask : t_regs
  // every lane code, id match and mask, cycle set, static and null options
  task t_filter;
    config_state <= 1'b1;
    apb(1'b1, ADDR_PARTITION, 32'h020B0400);
    frame(rj(LANE_NONE, 0, 0, 0, 0), 0, fr(0, 9, 0, 0, 0), 0);
    frame(rj(LANE_A_ONLY, 0, 0, 0, 0), 0, fr(0, 9, 0, 0, 0), 1);
    frame(rj(LANE_A_ONLY, 0, 0, 0, 0), 0, fr(1, 9, 0, 0, 0), 0);
    frame(rj(LANE_B_ONLY, 0, 0, 0, 0), 0, fr(1, 9, 0, 0, 0), 1);
    frame(rj(LANE_B_ONLY, 0, 0, 0, 0), 0, fr(0, 9, 0, 0, 0), 0);
    frame(rj(0, 5, 0, 0, 0), 0, fr(0, 5, 0, 0, 0), 0);
    frame(rj(0, 5, 0, 0, 0), 0, fr(0, 6, 0, 0, 0), 1);
    frame(rj(0, 5, 0, 0, 0), 1, fr(0, 4, 0, 0, 0), 0);
    frame(rj(0, 0, 0, 0, 0), 0, fr(0, 0, 0, 0, 0), 1);
    frame(rj(0, 0, 3, 0, 0), 0, fr(0, 9, 3, 0, 0), 1);
    frame(rj(0, 0, 3, 0, 0), 0, fr(0, 9, 2, 0, 0), 0);
    frame(rj(0, 0, 0, 1, 0), 0, fr(0, 9, 0, 1, 0), 0);
    frame(rj(0, 0, 0, 0, 0), 0, fr(0, 9, 0, 1, 0), 1);
    frame(rj(0, 0, 0, 0, 1), 0, fr(0, 9, 0, 0, 1), 0);
    drain_all(1'b1);
    config_state <= 1'b0;
    hdr(7'h00, 8'h10, 1'b0);
    hdr(7'h05, 8'h10, 1'b0);
    hdr(7'h02, 8'h80, 1'b0);
    hdr(7'h02, 8'h7F, 1'b1);
    hdr_wr_req <= 1'b0;
    $display("t_filter done");
  endtask : t_filter
  // both lanes stored, flag and sticky status around the threshold
  task t_thresh;
    config_state <= 1'b1;
    apb(1'b1, ADDR_THRESH, 32'h00000003);
    apb(1'b1, ADDR_IRQ, 32'h00000002);
    frame(0, 0, fr(0, 9, 0, 0, 0), 1);
    frame(0, 0, fr(1, 9, 0, 0, 0), 1);
    `CHK(fifo_fill_level, 8'h02)
    `CHK(fifo_threshold_flag, 1'b0)
    frame(0, 0, fr(0, 9, 0, 0, 0), 1);
    @(negedge pclk);
    `CHK(fifo_threshold_flag, 1'b1)
    `CHK(threshold_irq, 1'b1)
    @(posedge pclk);
    drain_all(1'b0);
    @(negedge pclk);
    `CHK(fifo_threshold_flag, 1'b0)
    `CHK(threshold_irq, 1'b1)
    @(posedge pclk);
    apb(1'b1, ADDR_IRQ, 32'h00000003);
    `CHK(threshold_irq, 1'b0)
    apb(1'b1, ADDR_THRESH, 32'h00000081);
    frame(0, 0, fr(0, 9, 0, 0, 0), 1);
    @(negedge pclk);
    `CHK(fifo_threshold_flag, 1'b0)
    @(posedge pclk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r, 32'h00000101)
    $display("t_thresh done");
  endtask : t_thresh
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, config_state, hdr_wr_req, drain, slow, presetn} = '0;
    {paddr, pwdata, hdr_wr_index, hdr_wr_words} = '0;
    rx_frame = '0;
    n_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_filter();
    t_thresh();
    stop_test();
  end
endmodule : test_rx_fifo_reject_filter
